// *** rtl/mcs_params.svh ***
// Constants for the modulation clock select block: offsets, fields, timing.
// Assumes inclusion by the package and by every design file that needs it.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// Register indices; byte address is four times the index
`define MCS_IDX_MOD_CTRL     8'h80
`define MCS_IDX_MOD_FREQ     8'h85
`define MCS_IDX_INT_LEN_HI   8'ha0
`define MCS_IDX_INT_LEN_LO   8'ha1
`define MCS_IDX_REP_HI       8'ha2
`define MCS_IDX_REP_LO       8'ha3
`define MCS_IDX_PART_VER     8'hfb
`define MCS_IDX_STATUS       8'h10
`define MCS_IDX_STRAP_CFG    8'h11

// Field positions
`define MCS_CTRL_START_BIT   0
`define MCS_CTRL_EXT_SEL_BIT 6
`define MCS_ST_BUSY_BIT      0
`define MCS_ST_INTEG_BIT     1
`define MCS_ST_READOUT_BIT   2
`define MCS_ST_STRAP_BIT     3
`define MCS_ST_EXT_ACT_BIT   6
// Only the select bit is stored; start reads back zero
`define MCS_CTRL_RW_MASK     8'h40

// Reset values
`define MCS_MOD_CTRL_RST     8'h00
`define MCS_MOD_FREQ_RST     8'h00
`define MCS_INT_LEN_RST      16'h0001
`define MCS_REP_RST          16'h0000
// Arbitrary neutral part version value
`define MCS_PART_VER_VAL     8'h01

// Divider setting for the external path: toggle every second edge
`define MCS_EXT_DIV_LIMIT    8'h01
`define MCS_REP_ONE          17'h00001
`define MCS_CNT_ONE          33'h000000001
`define MCS_RO_ONE           8'h01

// Timing
`define MCS_CLK_PERIOD_NS    100
`define MCS_STRAP_TIME_NS    1000
`define MCS_STRAP_CYCLES     ((`MCS_STRAP_TIME_NS + `MCS_CLK_PERIOD_NS - 1) / `MCS_CLK_PERIOD_NS)
`define MCS_READOUT_CYCLES   8'h20

`endif

// *** rtl/mcs_pkg.sv ***
// Types shared by the modulation clock select block.
// Assumes the params header is on the include path.
`include "mcs_params.svh"

package mcs_pkg;
    typedef enum logic [1:0] {
        MCS_ST_STRAP   = 2'b00,
        MCS_ST_IDLE    = 2'b01,
        MCS_ST_INTEG   = 2'b10,
        MCS_ST_READOUT = 2'b11
    } mcs_state_t;
endpackage

// *** rtl/mcs_toggle_div.sv ***
// Toggle divider: flips its output every limit+1 ticks.
// Assumes tick is a one-cycle enable in the clk domain.
`timescale 1ns/100ps
`default_nettype none

module mcs_toggle_div (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       tick,
    input  wire logic       clear,
    input  wire logic [7:0] limit,
    output var  logic       toggle_q
);
    logic [7:0] count_q;
    logic       wrap;

    // Terminal count; also catches a limit lowered below the count
    assign wrap = (count_q >= limit);

    // Counter and output flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q  <= 8'h00;
            toggle_q <= 1'b0;
        end else if (clear) begin
            count_q  <= 8'h00;
            toggle_q <= 1'b0;
        end else if (tick) begin
            count_q  <= wrap ? 8'h00 : count_q + 8'h01;
            toggle_q <= wrap ? ~toggle_q : toggle_q;
        end
    end
endmodule

`default_nettype wire

// *** rtl/mcs_top.sv ***
// Modulation clock select: source choice, integration timing, strap scan,
// illumination and video port gating, Avalon-MM register slave.
// Assumes all pins synchronous to clk; ext clock well below clk/2.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

`include "mcs_params.svh"

// Contract
// - select bit 1 routes external modulation clock to illumination and demodulator.
// - external mode modulation equals external clock divided by four.
// - external mode integration lasts (repeat+1) times length external periods.
// - internal frequency setting has no effect while external source selected.
// - illumination output and demodulator share one selected clock.
// - push-pull output low means open-drain driver off.
// - video port outputs stay static during integration.
// - straps sampled once right after reset release, preset configuration.
// - readable part version register identifies chip revision.
// - open-drain output toggles at internal rate or follows external clock; the code drives external clock divided by four.
// - video port outputs toggle no faster than 48 MHz.
// - strap pins are pulled-down inputs for four oscillator periods; the code holds them for 10 clk cycles.
module mcs_top
    import mcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    input  wire logic        external_modulation_clock,
    output var  logic        led_od_oe,
    output var  logic        push_pull_illumination_output,
    output var  logic        demod_clk,
    input  wire logic        frame_sync_address_strap0_i,
    output var  logic        frame_sync_address_strap0_o,
    output var  logic        frame_sync_address_strap0_oe,
    input  wire logic        line_sync_address_strap1_i,
    output var  logic        line_sync_address_strap1_o,
    output var  logic        line_sync_address_strap1_oe,
    output var  logic        strap_pulldown_en,
    input  wire logic [7:0]  video_data_in,
    output var  logic [7:0]  parallel_video_port_data
);
    mcs_state_t  state_q;
    mcs_state_t  state_d;
    logic [7:0]  ctrl_q;
    logic [7:0]  freq_q;
    logic [15:0] len_q;
    logic [15:0] rep_q;
    logic [1:0]  strap_q;
    logic        ext_act_q;
    logic        ext_smp_q;
    logic [32:0] int_cnt_q;
    logic [7:0]  gen_cnt_q;
    logic        int_mod;
    logic        ext_mod;
    logic        mod_sel;

    // Bus decode
    logic [7:0]  idx;
    logic        req;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    assign idx   = avs_address[9:2];
    assign req   = avs_read | avs_write;
    assign wr_en = avs_write & ~avs_waitrequest;
    assign rd_en = avs_read & avs_waitrequest;
    assign wdata = avs_writedata[7:0];

    // Sequencing terms
    logic        start_wr;
    logic        ext_rise;
    logic        int_tick;
    logic [32:0] int_target;
    logic        int_done;
    logic        strap_done;
    logic        ro_done;
    logic        integ;
    logic        readout;
    assign start_wr   = wr_en & (idx == `MCS_IDX_MOD_CTRL)
                      & wdata[`MCS_CTRL_START_BIT];
    assign ext_rise   = external_modulation_clock & ~ext_smp_q;
    // Ext mode counts external periods, internal mode counts clk cycles
    assign int_tick   = ext_act_q ? ext_rise : 1'b1;
    assign int_target = 33'({1'b0, rep_q} + `MCS_REP_ONE) * 33'(len_q);
    assign int_done   = int_tick & ((int_cnt_q + `MCS_CNT_ONE) >= int_target);
    assign strap_done = (gen_cnt_q == 8'(`MCS_STRAP_CYCLES - 1));
    assign ro_done    = (gen_cnt_q == (`MCS_READOUT_CYCLES - `MCS_RO_ONE));
    assign integ      = (state_q == MCS_ST_INTEG);
    assign readout    = (state_q == MCS_ST_READOUT);

    // Register read mux, unmapped indices read zero
    logic [7:0] status;
    assign status = {1'b0, ext_act_q, 2'b00, (state_q == MCS_ST_STRAP),
                     readout, integ, (state_q != MCS_ST_IDLE)};
    always_comb begin
        case (idx)
            `MCS_IDX_MOD_CTRL:   rdata = ctrl_q;
            `MCS_IDX_MOD_FREQ:   rdata = freq_q;
            `MCS_IDX_INT_LEN_HI: rdata = len_q[15:8];
            `MCS_IDX_INT_LEN_LO: rdata = len_q[7:0];
            `MCS_IDX_REP_HI:     rdata = rep_q[15:8];
            `MCS_IDX_REP_LO:     rdata = rep_q[7:0];
            `MCS_IDX_PART_VER:   rdata = `MCS_PART_VER_VAL;
            `MCS_IDX_STATUS:     rdata = status;
            `MCS_IDX_STRAP_CFG:  rdata = {6'h00, strap_q};
            default:             rdata = 8'h00;
        endcase
    end

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            MCS_ST_STRAP:   if (strap_done) state_d = MCS_ST_IDLE;
            MCS_ST_IDLE:    if (start_wr) state_d = MCS_ST_INTEG;
            MCS_ST_INTEG:   if (int_done) state_d = MCS_ST_READOUT;
            MCS_ST_READOUT: if (ro_done) state_d = MCS_ST_IDLE;
            default:        state_d = MCS_ST_IDLE;
        endcase
    end

    // Internal generator divides clk by twice (freq setting + 1)
    mcs_toggle_div u_int_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .tick     (1'b1),
        .clear    (1'b0),
        .limit    (freq_q),
        .toggle_q (int_mod)
    );

    // External path toggles every second rising edge: divide by four
    mcs_toggle_div u_ext_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .tick     (ext_rise),
        .clear    (~ext_act_q),
        .limit    (`MCS_EXT_DIV_LIMIT),
        .toggle_q (ext_mod)
    );

    // Source mux; freq setting never reaches the ext path
    assign mod_sel = ext_act_q ? ext_mod : int_mod;

    // Avalon-MM slave: one wait cycle, then answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (rd_en) begin
                avs_readdata <= {24'h000000, rdata};
            end
        end
    end

    // Writable configuration; select resets to internal source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `MCS_MOD_CTRL_RST;
            freq_q <= `MCS_MOD_FREQ_RST;
            len_q  <= `MCS_INT_LEN_RST;
            rep_q  <= `MCS_REP_RST;
        end else if (wr_en) begin
            case (idx)
                `MCS_IDX_MOD_CTRL:   ctrl_q <= wdata & `MCS_CTRL_RW_MASK;
                `MCS_IDX_MOD_FREQ:   freq_q <= wdata;
                `MCS_IDX_INT_LEN_HI: len_q[15:8] <= wdata;
                `MCS_IDX_INT_LEN_LO: len_q[7:0] <= wdata;
                `MCS_IDX_REP_HI:     rep_q[15:8] <= wdata;
                `MCS_IDX_REP_LO:     rep_q[7:0] <= wdata;
                default:             ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Strap register: caught at end of scan, writable afterwards
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_q <= 2'b00;
        end else if ((state_q == MCS_ST_STRAP) && strap_done) begin
            strap_q <= {line_sync_address_strap1_i,
                        frame_sync_address_strap0_i};
        end else if (wr_en && (idx == `MCS_IDX_STRAP_CFG)) begin
            strap_q <= wdata[1:0];
        end
    end

    // Sequencer, source latch only while idle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= MCS_ST_STRAP;
            ext_act_q <= 1'b0;
            ext_smp_q <= 1'b0;
            int_cnt_q <= 33'h000000000;
            gen_cnt_q <= 8'h00;
        end else begin
            state_q   <= state_d;
            ext_smp_q <= external_modulation_clock;
            if (state_q == MCS_ST_IDLE) begin
                ext_act_q <= ctrl_q[`MCS_CTRL_EXT_SEL_BIT];
            end
            if (!integ) begin
                int_cnt_q <= 33'h000000000;
            end else if (int_tick) begin
                int_cnt_q <= int_cnt_q + `MCS_CNT_ONE;
            end
            gen_cnt_q <= (state_d != state_q) ? 8'h00 : gen_cnt_q + 8'h01;
        end
    end

    // Illumination and demodulator outputs from one source
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            led_od_oe                     <= 1'b0;
            push_pull_illumination_output <= 1'b0;
            demod_clk                     <= 1'b0;
        end else begin
            led_od_oe                     <= integ & mod_sel;
            push_pull_illumination_output <= integ & mod_sel;
            demod_clk                     <= integ & mod_sel;
        end
    end

    // Strap pins and video port; video data frozen and sync outputs held low outside readout
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_pulldown_en            <= 1'b1;
            frame_sync_address_strap0_oe <= 1'b0;
            line_sync_address_strap1_oe  <= 1'b0;
            frame_sync_address_strap0_o  <= 1'b0;
            line_sync_address_strap1_o   <= 1'b0;
            parallel_video_port_data     <= 8'h00;
        end else begin
            strap_pulldown_en            <= (state_d == MCS_ST_STRAP);
            frame_sync_address_strap0_oe <= (state_d != MCS_ST_STRAP);
            line_sync_address_strap1_oe  <= (state_d != MCS_ST_STRAP);
            if (readout) begin
                // One update per clk, far below 48 MHz
                frame_sync_address_strap0_o <= 1'b1;
                line_sync_address_strap1_o  <= ~line_sync_address_strap1_o;
                parallel_video_port_data    <= video_data_in;
            end else begin
                frame_sync_address_strap0_o <= 1'b0;
                line_sync_address_strap1_o  <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** bench/mcs_chk.sv ***
// Checker on the top ports of the modulation clock select block.
// Assumes one clk domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mcs_chk (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       led_od_oe,
    input wire logic       push_pull_illumination_output,
    input wire logic       demod_clk,
    input wire logic       frame_sync_address_strap0_o,
    input wire logic       line_sync_address_strap1_o,
    input wire logic       frame_sync_address_strap0_oe,
    input wire logic       line_sync_address_strap1_oe,
    input wire logic       strap_pulldown_en,
    input wire logic [7:0] parallel_video_port_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Illumination pair and demodulator
    a_illum_same: assert property (push_pull_illumination_output == led_od_oe)
        else $error("illumination outputs differ");
    a_demod_shared: assert property (demod_clk == led_od_oe)
        else $error("demodulator clock differs from illumination");
    // Register bus answer timing
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    // Strap scan
    a_strap_inputs: assert property (strap_pulldown_en |->
        !frame_sync_address_strap0_oe && !line_sync_address_strap1_oe)
        else $error("strap pin driven during scan");
    a_strap_length: assert property ($rose(reset_n) |-> strap_pulldown_en [*8]
        ##1 strap_pulldown_en ##1 strap_pulldown_en ##1 !strap_pulldown_en)
        else $error("strap scan length wrong");
    a_scan_once: assert property ($fell(strap_pulldown_en) |=> !strap_pulldown_en [*8])
        else $error("strap scan repeated");
    // Video port quiet outside readout
    a_video_static: assert property (!frame_sync_address_strap0_o &&
        !$past(frame_sync_address_strap0_o) |-> $stable(parallel_video_port_data))
        else $error("video port moved outside readout");
    // Line sync only moves while frame sync marks readout
    a_line_quiet: assert property (line_sync_address_strap1_o |->
        frame_sync_address_strap0_o)
        else $error("line sync moved outside readout");
endmodule
bind mcs_top mcs_chk mcs_chk_inst (.clk(clk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .led_od_oe(led_od_oe),
    .push_pull_illumination_output(push_pull_illumination_output),
    .demod_clk(demod_clk),
    .frame_sync_address_strap0_o(frame_sync_address_strap0_o),
    .line_sync_address_strap1_o(line_sync_address_strap1_o),
    .frame_sync_address_strap0_oe(frame_sync_address_strap0_oe),
    .line_sync_address_strap1_oe(line_sync_address_strap1_oe),
    .strap_pulldown_en(strap_pulldown_en),
    .parallel_video_port_data(parallel_video_port_data));
`default_nettype wire

// *** bench/mcs_ext_src.sv ***
// Model of the external modulation clock source.
// Assumes the bench clock; output stands low between frames.
`timescale 1ns/100ps
`default_nettype none
module mcs_ext_src #(parameter int HALF = 4) (
    input  wire logic clk,
    input  wire logic en,
    output var  logic ext_q
);
    int cnt = 0;
    initial ext_q = 1'b0;
    // Square wave while a frame runs, far below the limit
    always @(posedge clk) begin
        if (!en) begin
            cnt <= 0;
            ext_q <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            ext_q <= ~ext_q;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// *** bench/mcs_top_tb.sv ***
// Testbench: Avalon-MM register tasks, strap resistors, acquisitions.
// Assumes mcs_top, the source model and the checker bind are compiled.
`timescale 1ns/100ps
`default_nettype none
module mcs_top_tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ext_en = 1'b0;
    logic        win = 1'b0;
    logic        ext_p = 1'b0;
    logic        led_p = 1'b0;
    logic [7:0]  vin = 8'h00;
    int          num_errors = 0;
    int          checks = 0;
    int          ext_n = 0;
    int          led_n = 0;
    wire         wreq, ext_clk, led, s0_o, s0_oe, s1_o, s1_oe;
    wire  [31:0] rdq;
    wire  [7:0]  vout;
    // Pull-up on strap0, pull-down on strap1
    wire         s0_pin = s0_oe ? s0_o : 1'b1;
    wire         s1_pin = s1_oe ? s1_o : 1'b0;

    mcs_top mcs_top_inst (.clk(clk), .reset_n(reset_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
        .avs_readdata(rdq), .avs_waitrequest(wreq),
        .external_modulation_clock(ext_clk), .led_od_oe(led),
        .push_pull_illumination_output(), .demod_clk(),
        .frame_sync_address_strap0_i(s0_pin),
        .frame_sync_address_strap0_o(s0_o),
        .frame_sync_address_strap0_oe(s0_oe),
        .line_sync_address_strap1_i(s1_pin),
        .line_sync_address_strap1_o(s1_o),
        .line_sync_address_strap1_oe(s1_oe), .strap_pulldown_en(),
        .video_data_in(vin), .parallel_video_port_data(vout));
    mcs_ext_src #(.HALF(4)) mcs_ext_src_inst (.clk(clk), .en(ext_en),
        .ext_q(ext_clk));

    // Clock runs from time zero, before reset release
    always #50 clk = ~clk;
    // Edge counters; only the open-drain output is used
    always @(posedge clk) begin
        vin <= vin + 8'h01;
        ext_p <= ext_clk;
        led_p <= led;
        ext_n <= win ? ext_n + (ext_clk & ~ext_p) : 0;
        led_n <= win ? led_n + (led & ~led_p) : 0;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= {idx, 2'b00};
        wdat <= d;
        rd <= ~w;
        wr <= w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wreq === 1'b0)
                break;
        end
        if (n == 50) begin
            num_errors++;
            tally_and_finish();
        end
        rdat = rdq;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic acq(input logic ext, input int ticks, rises, tol);
        int n;
        logic       moved;
        logic [7:0] v0;
        bus(1'b1, 8'h80, {25'h0, ext, 6'h00});
        win <= 1'b1;
        bus(1'b1, 8'h80, {25'h0, ext, 6'h01});
        ext_en <= 1'b1;
        moved = 1'b0;
        v0 = vout;
        // Video port must not move until readout shows frame sync
        for (n = 0; n < 3000 && s0_o !== 1'b1; n++) begin
            if (vout !== v0)
                moved = 1'b1;
            @(posedge clk);
        end
        check("frame end", n < 3000, 1'b1);
        check("video static", moved, 1'b0);
        if (ext)
            check("ext ticks", ext_n, ticks);
        check("led rises", led_n >= rises - tol && led_n <= rises + tol, 1);
        ext_en <= 1'b0;
        win <= 1'b0;
        for (n = 0; n < 100; n++) begin
            bus(1'b0, 8'h10, 32'h0);
            if (rdat[0] === 1'b0)
                break;
        end
        check("idle again", n < 100, 1'b1);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        bus(1'b0, 8'h11, 32'h0);
        check("strap cfg", rdat, 32'h1);
        bus(1'b1, 8'h11, 32'h2);
        bus(1'b0, 8'h11, 32'h0);
        check("strap write", rdat, 32'h2);
        bus(1'b0, 8'h80, 32'h0);
        check("ctrl reset", rdat, 32'h0);
        bus(1'b1, 8'hfb, 32'h5a);
        bus(1'b0, 8'hfb, 32'h0);
        check("part version", rdat, 32'h1);
        bus(1'b0, 8'hff, 32'h0);
        check("unmapped", rdat, 32'h0);
        $display("register test done");
        bus(1'b1, 8'h85, 32'h3);
        bus(1'b1, 8'ha0, 32'h0);
        bus(1'b1, 8'ha1, 32'h40);
        bus(1'b1, 8'ha2, 32'h0);
        bus(1'b1, 8'ha3, 32'h0);
        acq(1'b0, 0, 8, 1);
        $display("internal source test done");
        bus(1'b1, 8'h85, 32'h7);
        bus(1'b1, 8'ha1, 32'h8);
        bus(1'b1, 8'ha3, 32'h1);
        acq(1'b1, 16, 4, 0);
        $display("external source test done");
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (12) @(posedge clk);
        bus(1'b0, 8'h11, 32'h0);
        check("strap again", rdat, 32'h1);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
